/* File: logic/capcmp_pkg.sv */
package capcmp_pkg;
    // register byte addresses, one aligned word each
    localparam logic [7:0] channel_one_value_low_addr  = 8'h00;
    localparam logic [7:0] channel_one_value_high_addr = 8'h04;
    localparam logic [7:0] channel_one_control_addr    = 8'h08;
    localparam logic [7:0] channel_two_value_low_addr  = 8'h0C;
    localparam logic [7:0] channel_two_value_high_addr = 8'h10;
    localparam logic [7:0] channel_two_control_addr    = 8'h14;
    localparam logic [7:0] channel_stride              = 8'h0C;
    // control register fields
    localparam int         duty_lsb_pos      = 4;
    localparam int         mode_pos          = 0;
    localparam logic [7:0] control_writable  = 8'h3F;
    localparam logic [7:0] control_reset     = 8'h00;
    localparam logic [7:0] value_reset       = 8'h00;
    localparam logic [9:0] duty_reset        = 10'h000;
    // mode select encodings
    localparam logic [1:0] mode_group_off     = 2'h0;
    localparam logic [1:0] mode_group_capture = 2'h1;
    localparam logic [1:0] mode_group_compare = 2'h2;
    localparam logic [1:0] mode_group_pwm     = 2'h3;
    localparam logic [3:0] mode_special_event = 4'hB;
    // decoded channel modes
    typedef enum logic [1:0] {
        mode_off,
        mode_capture,
        mode_compare,
        mode_pwm
    } chan_mode_e;
endpackage

/* File: logic/dual_capture_compare.sv */
`timescale 1ns/1ps
// Summary of operation
// - each channel holds a 16-bit value: capture, compare or PWM duty register
// - the 16-bit value is reached as separate low and high byte registers
// - each channel has its own control register selecting its mode
// - both channels behave alike except for the special event effect
// - channel one special event resets the 16-bit time-base timer
// - channel two special event resets timer and starts A/D when enabled
// - capture and compare use the 16-bit timer, PWM the 8-bit period timer
// - PWM channels share period and duty update at the period timer event
// - control bits 5 and 4 hold the two low PWM duty bits
module dual_capture_compare (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timers and converter
    input  wire logic [15:0] wide_timebase_count,
    input  wire logic [7:0]  period_timer_count,
    input  wire logic        period_timer_event,
    input  wire logic        ad_module_enabled,
    // capture pins, one per channel
    input  wire logic [1:0]  capture_in,
    // event and waveform outputs
    output logic             timebase_reset,
    output logic             ad_start,
    output logic      [1:0]  compare_match,
    output logic      [1:0]  pwm_out
);

    logic [7:0]  value_low  [2];
    logic [7:0]  value_high [2];
    logic [7:0]  control    [2];
    logic [9:0]  duty_active [2];
    logic [1:0]  capture_prev;
    logic [1:0]  equal_prev;
    logic [1:0]  equal_now;
    logic [1:0]  capture_edge;
    logic [1:0]  special_hit;
    logic        access;
    logic        do_write;
    logic [7:0]  read_value;
    logic        addr_mapped;

    // mode decode from the select field
    function automatic capcmp_pkg::chan_mode_e decode_mode(input logic [7:0] ctl);
        logic [1:0] grp;
        grp = ctl[capcmp_pkg::mode_pos+3 -: 2];
        if (grp == capcmp_pkg::mode_group_capture) decode_mode = capcmp_pkg::mode_capture;
        else if (grp == capcmp_pkg::mode_group_compare) decode_mode = capcmp_pkg::mode_compare;
        else if (grp == capcmp_pkg::mode_group_pwm) decode_mode = capcmp_pkg::mode_pwm;
        else decode_mode = capcmp_pkg::mode_off;
    endfunction

    // register address of a channel slot
    function automatic logic [7:0] chan_addr(input int ch, input logic [7:0] base);
        chan_addr = 8'(base + ch * capcmp_pkg::channel_stride);
    endfunction

    // first access cycle, and the completion edge at which a write lands
    assign access   = psel && penable && !pready;
    assign do_write = psel && penable && pready && pwrite;

    // per-channel event detection against the 16-bit timer
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            equal_now[ch]    = (decode_mode(control[ch]) == capcmp_pkg::mode_compare) &&
                               ({value_high[ch], value_low[ch]} == wide_timebase_count);
            capture_edge[ch] = (decode_mode(control[ch]) == capcmp_pkg::mode_capture) &&
                               capture_in[ch] && !capture_prev[ch];
            special_hit[ch]  = equal_now[ch] && !equal_prev[ch] &&
                               (control[ch][3:0] == capcmp_pkg::mode_special_event);
        end
    end

    // read decode: selected byte and whether the address is mapped
    always_comb begin
        read_value  = 8'h00;
        addr_mapped = 1'b1;
        if (paddr == capcmp_pkg::channel_one_value_low_addr) begin
            read_value = value_low[0];
        end else if (paddr == capcmp_pkg::channel_one_value_high_addr) begin
            read_value = value_high[0];
        end else if (paddr == capcmp_pkg::channel_one_control_addr) begin
            read_value = control[0];
        end else if (paddr == capcmp_pkg::channel_two_value_low_addr) begin
            read_value = value_low[1];
        end else if (paddr == capcmp_pkg::channel_two_value_high_addr) begin
            read_value = value_high[1];
        end else if (paddr == capcmp_pkg::channel_two_control_addr) begin
            read_value = control[1];
        end else begin
            addr_mapped = 1'b0;
        end
    end

    // apb handshake: one wait state, then a one-cycle answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    // error answer for an unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access && !addr_mapped;
        end
    end

    // read data, standing only in the answer cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= access ? {24'h000000, read_value} : 32'h00000000;
        end
    end

    // value bytes: capture load wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int ch = 0; ch < 2; ch++) begin
                value_low[ch]  <= capcmp_pkg::value_reset;
                value_high[ch] <= capcmp_pkg::value_reset;
            end
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (capture_edge[ch]) begin
                    value_low[ch]  <= wide_timebase_count[7:0];
                    value_high[ch] <= wide_timebase_count[15:8];
                end else if (do_write) begin
                    if (paddr == chan_addr(ch, capcmp_pkg::channel_one_value_low_addr)) begin
                        value_low[ch] <= pwdata[7:0];
                    end else if (paddr == chan_addr(ch, capcmp_pkg::channel_one_value_high_addr)) begin
                        value_high[ch] <= pwdata[7:0];
                    end
                end
            end
        end
    end

    // control registers, writable bits only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int ch = 0; ch < 2; ch++) begin
                control[ch] <= capcmp_pkg::control_reset;
            end
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (do_write && paddr == chan_addr(ch, capcmp_pkg::channel_one_control_addr)) begin
                    control[ch] <= pwdata[7:0] & capcmp_pkg::control_writable;
                end
            end
        end
    end

    // capture pin history, idle low after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_prev <= 2'h0;
        end else begin
            capture_prev <= capture_in;
        end
    end

    // match history, so one equality run gives one pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            equal_prev <= 2'h0;
        end else begin
            equal_prev <= equal_now;
        end
    end

    // compare match and special event outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_match  <= 2'h0;
            timebase_reset <= 1'b0;
            ad_start       <= 1'b0;
        end else begin
            compare_match  <= equal_now & ~equal_prev;
            timebase_reset <= special_hit[0] || special_hit[1];
            ad_start       <= special_hit[1] && ad_module_enabled;
        end
    end

    // pwm duty latched at the shared period event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int ch = 0; ch < 2; ch++) begin
                duty_active[ch] <= capcmp_pkg::duty_reset;
            end
        end else if (period_timer_event) begin
            for (int ch = 0; ch < 2; ch++) begin
                duty_active[ch] <= {value_low[ch], control[ch][capcmp_pkg::duty_lsb_pos+1 -: 2]};
            end
        end
    end

    // pwm waveform against the 8-bit period timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= 2'h0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                pwm_out[ch] <= (decode_mode(control[ch]) == capcmp_pkg::mode_pwm) &&
                               ({period_timer_count, 2'h0} < duty_active[ch]);
            end
        end
    end

endmodule // dual_capture_compare

/* File: testbench/capcmp_props.sv */
`timescale 1ns/1ps
module capcmp_props (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // converter and events
    input wire logic        ad_module_enabled,
    input wire logic        timebase_reset,
    input wire logic        ad_start,
    input wire logic [1:0]  compare_match
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access taken, then one-cycle answer
    sequence s_taken; psel && penable && !pready; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    sequence s_ctl_read; pready && !pwrite && (paddr == capcmp_pkg::channel_one_control_addr
        || paddr == capcmp_pkg::channel_two_control_addr); endsequence
    property p_answer; s_taken |=> s_answer; endproperty
    property p_ctl_top; s_ctl_read |-> prdata[31:6] == 26'h0000000; endproperty
    property p_byte; pready |-> prdata[31:8] == 24'h000000; endproperty
    property p_err; pready && pslverr |-> prdata == 32'h00000000; endproperty
    property p_tbr; timebase_reset |-> |compare_match; endproperty
    property p_ad_tbr; ad_start |-> timebase_reset && compare_match[1]; endproperty
    property p_ad_off; !ad_module_enabled && !$past(ad_module_enabled) |-> !ad_start; endproperty
    property p_one_noad; compare_match == 2'h1 |-> !ad_start; endproperty
    a_answer: assert property (p_answer) else $error("no single-cycle answer");
    a_ctl_top: assert property (p_ctl_top) else $error("control top bits set");
    a_byte: assert property (p_byte) else $error("read data wider than a byte");
    a_err: assert property (p_err) else $error("error read with data");
    a_tbr: assert property (p_tbr) else $error("timebase reset without match");
    a_ad_tbr: assert property (p_ad_tbr) else $error("converter start without channel two event");
    a_ad_off: assert property (p_ad_off) else $error("converter start while disabled");
    a_one_noad: assert property (p_one_noad) else $error("channel one started converter");
endmodule // capcmp_props

/* File: testbench/timer_model.sv */
`timescale 1ns/1ps
module timer_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // special event from the block
    input  wire logic        timebase_reset,
    // timer counts and period event
    output logic      [15:0] wide_timebase_count,
    output logic      [7:0]  period_timer_count,
    output logic             period_timer_event
);
    // 16-bit time base, cleared by the special event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wide_timebase_count <= 16'h0000;
        else if (timebase_reset) wide_timebase_count <= 16'h0000;
        else wide_timebase_count <= wide_timebase_count + 16'h0001;
    end
    // 64-count period timer with one event per wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_timer_count <= 8'h00;
            period_timer_event <= 1'b0;
        end else begin
            period_timer_count <= (period_timer_count == 8'h3F) ? 8'h00 : period_timer_count + 8'h01;
            period_timer_event <= (period_timer_count == 8'h3F);
        end
    end
endmodule // timer_model

/* File: testbench/test_dual_capture_compare.sv */
`timescale 1ns/1ps
module test_dual_capture_compare;
    logic        pclk, presetn, psel, penable, pwrite, ad_en, pready, pslverr, perr, pev, tbr, ads;
    logic [7:0]  paddr, pcount, b;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] wcount, snap, t;
    logic [1:0]  cap, cmatch, pwm;
    int          error_cnt, samples_checked, n_tbr, n_ad, hi0, hi1;
    int          n_cm [2];
    dual_capture_compare dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .wide_timebase_count(wcount), .period_timer_count(pcount), .period_timer_event(pev),
        .ad_module_enabled(ad_en), .capture_in(cap), .timebase_reset(tbr), .ad_start(ads),
        .compare_match(cmatch), .pwm_out(pwm));
    timer_model partner (.pclk, .presetn, .timebase_reset(tbr), .wide_timebase_count(wcount),
        .period_timer_count(pcount), .period_timer_event(pev));
    // clock, event counters, watchdog
    initial begin pclk = 0; forever #2.5 pclk = ~pclk; end
    always @(posedge pclk) begin n_tbr += tbr; n_ad += ads; n_cm[0] += cmatch[0]; n_cm[1] += cmatch[1]; end
    initial begin #200000; error_cnt++; results; end
    task chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin error_cnt++; $display("wrong value %s expected %h seen %h", nm, exp, seen); end
    endtask
    // one apb transfer, held until pready is sampled high
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk); psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata; perr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task results;
        if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; ad_en = 1; cap = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (int c = 0; c < 2; c++) begin
            b = 8'(c) * capcmp_pkg::channel_stride;
            for (int r = 0; r < 3; r++) begin xfer(0, b + 8'(4 * r), 0); chk("reset", rdata, 0); end
            xfer(1, b + 8'h08, 32'hFF); xfer(0, b + 8'h08, 0); chk("control", rdata, 32'h3F);
            xfer(1, b, 32'h5A); xfer(1, b + 8'h04, 32'hA5);
            xfer(0, b, 0); chk("value low", rdata, 32'h5A);
            xfer(0, b + 8'h04, 0); chk("value high", rdata, 32'hA5);
            xfer(1, b + 8'h08, 32'h04);
            @(posedge pclk); cap <= 2'(1 << c);
            @(posedge pclk); snap = wcount; cap <= 0;
            xfer(0, b, 0); chk("captured low", rdata, 32'(snap[7:0]));
            xfer(0, b + 8'h04, 0); chk("captured high", rdata, 32'(snap[15:8]));
            for (int e = 1; e >= 0; e--) begin
                ad_en <= e[0]; t = wcount + 16'h0100;
                xfer(1, b, 32'(t[7:0])); xfer(1, b + 8'h04, 32'(t[15:8]));
                n_tbr = 0; n_ad = 0; n_cm[c] = 0; xfer(1, b + 8'h08, 32'h0B);
                wait (n_tbr == 2);
                chk("converter starts", n_ad, (c == 1 && e == 1) ? 2 : 0);
                chk("special compare matches", n_cm[c], 2);
                xfer(1, b + 8'h08, 32'h00);
            end
            // plain compare: one match pulse, no time-base reset
            t = wcount + 16'h0040;
            xfer(1, b, 32'(t[7:0])); xfer(1, b + 8'h04, 32'(t[15:8]));
            n_tbr = 0; n_cm[c] = 0; xfer(1, b + 8'h08, 32'h08);
            repeat (80) @(posedge pclk);
            chk("plain compare matches", n_cm[c], 1);
            chk("plain compare resets", n_tbr, 0);
            xfer(1, b + 8'h08, 32'h00);
        end
        xfer(1, 8'h00, 32'h20); xfer(1, 8'h0C, 32'h20); xfer(1, 8'h08, 32'h0C); xfer(1, 8'h14, 32'h3C);
        repeat (70) @(posedge pclk);
        hi0 = 0; hi1 = 0;
        repeat (64) begin @(posedge pclk); hi0 += pwm[0]; hi1 += pwm[1]; end
        chk("duty one", hi0, 32);
        chk("duty two", hi1, 33);
        xfer(0, 8'h18, 0); chk("unmapped", perr, 1);
        results;
    end
endmodule // test_dual_capture_compare
bind dual_capture_compare capcmp_props props (.*);
